// File: logic/dgp_dual_port.v
/*
  Eight-line wide port and four-line narrow port with data latches, direction
  registers and pin sharing with LCD segment/common, CCP and analog functions.
  The wide port carries the LCD common on line 0, the second capture/compare/PWM
  function on line 2 and LCD segments 16 to 20 on lines 3 to 7. The narrow
  port carries segments 21 to 23 on its three low lines; its top line is an
  input only and shares its pin with master clear.
  Assumes a single-cycle register port on clk with read data one cycle after
  the strobe; the pins are resolved outside from the output and enable
  signals; pin levels arrive asynchronously; the LCD, CCP and A/D internals
  live elsewhere and hand in their drive values.
*/
`include "dgp_consts.vh"

module dgp_dual_port (
  input  wire                     clk,
  input  wire                     nrst,
  input  wire [`DGP_ADDR_W-1:0]   reg_addr,
  input  wire [7:0]               reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  output reg  [7:0]               reg_rdata,
  input  wire                     master_clear_enable_fuse,
  input  wire [`DGP_WIDE_W-1:0]   wide_port_in,
  output wire [`DGP_WIDE_W-1:0]   wide_port_out,
  output wire [`DGP_WIDE_W-1:0]   wide_port_oe,
  input  wire [`DGP_NARROW_W-1:0] narrow_port_in,
  output wire [2:0]               narrow_port_low_lines_out,
  output wire [2:0]               narrow_port_low_lines_oe,
  input  wire                     ccp_out,
  input  wire                     ccp_out_en,
  output wire                     ccp_capture_in,
  input  wire [7:0]               lcd_segment_line,
  input  wire [7:0]               lcd_segment_drive_en,
  input  wire                     lcd_common_line,
  input  wire                     lcd_common_drive_en,
  output wire [7:0]               analog_select_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [`DGP_WIDE_W-1:0]   wide_latch_q;
  reg  [`DGP_WIDE_W-1:0]   wide_port_direction_q;
  reg  [2:0]               narrow_latch_q;
  reg  [2:0]               narrow_port_direction_q;
  reg  [7:0]               analog_select_q;
  reg  [7:0]               segment_enable_bank_two_q;
  reg  [7:0]               periph_ctrl_q;
  wire [`DGP_WIDE_W-1:0]   wide_pin_s;
  wire [`DGP_NARROW_W-1:0] narrow_pin_s;
  reg  [7:0]               rd_mux;
  reg  [`DGP_WIDE_W-1:0]   wide_drv_d;
  reg  [`DGP_WIDE_W-1:0]   wide_oe_d;
  reg  [2:0]               narrow_drv_d;
  reg  [2:0]               narrow_oe_d;
  reg  [`DGP_WIDE_W-1:0]   wide_drv_q;
  reg  [`DGP_WIDE_W-1:0]   wide_oe_q;
  reg  [2:0]               narrow_drv_q;
  reg  [2:0]               narrow_oe_q;
  wire [7:0]               narrow_seg_en;
  wire [7:0]               wide_seg_en;
  wire [`DGP_WIDE_W-1:0]   wide_seg_val;
  wire [`DGP_WIDE_W-1:0]   wide_seg_oe;
  wire [2:0]               narrow_seg_val;
  wire [2:0]               narrow_seg_oe;
  wire                     wr_wide_data;
  wire                     wr_narrow_data;
  wire                     wr_wide_dir;
  wire                     wr_narrow_dir;
  wire                     wr_analog_sel;
  wire                     wr_seg_enable;
  wire                     wr_periph_ctrl;

  function hit;
    input [`DGP_ADDR_W-1:0] a;
    input [`DGP_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Each register answers to one full address; a write to an address that
  // matches none of them is dropped.
  assign wr_wide_data   = reg_wr & hit(reg_addr, `DGP_OFS_WIDE_DATA);
  assign wr_narrow_data = reg_wr & hit(reg_addr, `DGP_OFS_NARROW_DATA);
  assign wr_wide_dir    = reg_wr & hit(reg_addr, `DGP_OFS_WIDE_DIR);
  assign wr_narrow_dir  = reg_wr & hit(reg_addr, `DGP_OFS_NARROW_DIR);
  assign wr_analog_sel  = reg_wr & hit(reg_addr, `DGP_OFS_ANALOG_SEL);
  assign wr_seg_enable  = reg_wr & hit(reg_addr, `DGP_OFS_SEG_ENABLE);
  assign wr_periph_ctrl = reg_wr & hit(reg_addr, `DGP_OFS_PERIPH_CTRL);

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  dgp_sync2 #(.W(`DGP_WIDE_W)) u_wide_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (wide_port_in),
    .sync_out (wide_pin_s)
  );

  dgp_sync2 #(.W(`DGP_NARROW_W)) u_narrow_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (narrow_port_in),
    .sync_out (narrow_pin_s)
  );

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // The data latches get a defined zero here only to keep simulation clean;
  // software must not rely on it.
  // Bit 3 of the narrow direction is not stored: that line can never drive.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wide_latch_q              <= 8'h00;
      narrow_latch_q            <= 3'h0;
      wide_port_direction_q     <= `DGP_DIR_RESET;
      narrow_port_direction_q   <= `DGP_NDIR_LOW_RESET;
      analog_select_q           <= `DGP_ANALOG_SELECT_RESET;
      segment_enable_bank_two_q <= `DGP_SEG_RESET;
      periph_ctrl_q             <= `DGP_PCTRL_RESET;
    end
    else
    begin
      if (wr_wide_data)
        wide_latch_q <= reg_wdata;
      if (wr_narrow_data)
        narrow_latch_q <= reg_wdata[2:0];
      if (wr_wide_dir)
        wide_port_direction_q <= reg_wdata;
      if (wr_narrow_dir)
        narrow_port_direction_q <= reg_wdata[2:0];
      if (wr_analog_sel)
        analog_select_q <= reg_wdata;
      if (wr_seg_enable)
        segment_enable_bank_two_q <= reg_wdata;
      if (wr_periph_ctrl)
        periph_ctrl_q <= reg_wdata;
    end
  end

  // ****************************************************************
  // Read path: data stands in the cycle after the strobe only
  // ****************************************************************
  // Pin reads see the synchronised level, so a pin change shows up in read
  // data three clock edges after it reaches the block.
  always @*
  begin
    case (reg_addr)
      `DGP_OFS_WIDE_DATA:
        rd_mux = wide_pin_s;
      `DGP_OFS_NARROW_DATA:
        rd_mux = {4'h0,
                  narrow_pin_s[`DGP_INPUT_ONLY_BIT] & ~master_clear_enable_fuse,
                  narrow_pin_s[2:0]};
      `DGP_OFS_WIDE_DIR:
        rd_mux = wide_port_direction_q;
      `DGP_OFS_NARROW_DIR:
        rd_mux = {4'h0, 1'b1, narrow_port_direction_q};
      `DGP_OFS_ANALOG_SEL:
        rd_mux = analog_select_q;
      `DGP_OFS_SEG_ENABLE:
        rd_mux = segment_enable_bank_two_q;
      `DGP_OFS_PERIPH_CTRL:
        rd_mux = periph_ctrl_q;
      default:
        rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rd_mux;
      else
        reg_rdata <= 8'h00;
    end
  end

  // ****************************************************************
  // Pin drive selection
  // ****************************************************************
  // Segment 16..23 enables: bits 0..4 go to wide lines 3..7, bits 5..7 to
  // the narrow low lines. Segment values and drives are lined up with the
  // port lines here so that each line indexes only its own bit.
  assign wide_seg_en    = {segment_enable_bank_two_q[4:0], 3'b000};
  assign narrow_seg_en  = {5'b00000, segment_enable_bank_two_q[7:5]};
  assign wide_seg_val   = {lcd_segment_line[4:0], 3'b000};
  assign wide_seg_oe    = {lcd_segment_drive_en[4:0], 3'b000};
  assign narrow_seg_val = lcd_segment_line[7:5];
  assign narrow_seg_oe  = lcd_segment_drive_en[7:5];

  // Peripheral ownership beats the port latch; an owning LCD function with
  // its drive disabled leaves the pin floating rather than falling back.
  genvar gi;
  generate
    for (gi = 0; gi < `DGP_WIDE_W; gi = gi + 1)
    begin : g_wide
      always @*
      begin
        wide_drv_d[gi] = wide_latch_q[gi];
        wide_oe_d[gi]  = ~wide_port_direction_q[gi];
        if (gi == 0 && periph_ctrl_q[`DGP_PCTRL_COM_EN_BIT])
        begin
          wide_drv_d[gi] = lcd_common_line;
          wide_oe_d[gi]  = lcd_common_drive_en;
        end
        else if (gi == `DGP_CCP_LINE && periph_ctrl_q[`DGP_PCTRL_CCP_EN_BIT] && ccp_out_en)
        begin
          wide_drv_d[gi] = ccp_out;
          wide_oe_d[gi]  = ~wide_port_direction_q[gi];
        end
        else if (gi >= `DGP_SEG_FIRST_LINE && wide_seg_en[gi])
        begin
          wide_drv_d[gi] = wide_seg_val[gi];
          wide_oe_d[gi]  = wide_seg_oe[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Narrow port drive selection
  // ****************************************************************
  // A line handed to the analog input never drives, whatever its direction, unless its segment enable claims it.
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_narrow
      always @*
      begin
        narrow_drv_d[gi] = narrow_latch_q[gi];
        narrow_oe_d[gi]  = ~narrow_port_direction_q[gi];
        if (narrow_seg_en[gi])
        begin
          narrow_drv_d[gi] = narrow_seg_val[gi];
          narrow_oe_d[gi]  = narrow_seg_oe[gi];
        end
        else if (analog_select_q[`DGP_ANALOG_SELECT_NARROW_LSB+gi])
        begin
          narrow_oe_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // Drive and enable are registered so the pins never see a glitch from the
  // selection logic; the cost is one cycle of latency after a register write.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wide_drv_q   <= 8'h00;
      wide_oe_q    <= 8'h00;
      narrow_drv_q <= 3'h0;
      narrow_oe_q  <= 3'h0;
    end
    else
    begin
      wide_drv_q   <= wide_drv_d;
      wide_oe_q    <= wide_oe_d;
      narrow_drv_q <= narrow_drv_d;
      narrow_oe_q  <= narrow_oe_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wide_port_out             = wide_drv_q;
  assign wide_port_oe              = wide_oe_q;
  assign narrow_port_low_lines_out = narrow_drv_q;
  assign narrow_port_low_lines_oe  = narrow_oe_q;
  assign ccp_capture_in            = wide_pin_s[`DGP_CCP_LINE];
  assign analog_select_out         = analog_select_q;

endmodule // dgp_dual_port

// File: common/dgp_consts.vh
/*
  Constants for the dual GPIO port block: register offsets, field positions,
  reset values and widths.
  Assumes it is included by bare name from the design files.
*/
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DGP_ADDR_W            9
`define DGP_OFS_WIDE_DATA     9'h008
`define DGP_OFS_NARROW_DATA   9'h009
`define DGP_OFS_WIDE_DIR      9'h088
`define DGP_OFS_NARROW_DIR    9'h089
`define DGP_OFS_ANALOG_SEL    9'h091
`define DGP_OFS_SEG_ENABLE    9'h11E
`define DGP_OFS_PERIPH_CTRL   9'h0A0

// ****************************************************************
// Widths, fields and reset values
// ****************************************************************
`define DGP_WIDE_W            8
`define DGP_NARROW_W          4
`define DGP_INPUT_ONLY_BIT    3
`define DGP_CCP_LINE          2
`define DGP_SEG_FIRST_LINE    3
`define DGP_DIR_RESET         8'hFF
`define DGP_NDIR_RESET        4'hF
`define DGP_NDIR_LOW_RESET    3'h7
`define DGP_ANALOG_SELECT_RESET       8'hFF
`define DGP_SEG_RESET         8'h00
`define DGP_PCTRL_RESET       8'h00
`define DGP_PCTRL_CCP_EN_BIT  0
`define DGP_PCTRL_COM_EN_BIT  1
`define DGP_ANALOG_SELECT_NARROW_LSB  5

`endif

// File: logic/dgp_sync2.v
/*
  Two-flop synchroniser for a bus of pin levels.
  Assumes the inputs come from pins outside the clk domain.
*/
module dgp_sync2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] stable_q;

  // The first stage is read only by the second stage.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q   <= {W{1'b0}};
      stable_q <= {W{1'b0}};
    end
    else
    begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule // dgp_sync2

// File: bench/dgp_chk_asserts.sv
/*
  Checker for the dual GPIO port block, watching its top module ports.
  Assumes the register strobes and pin timing of the hand-over contract.
*/
`include "dgp_consts.vh"
module dgp_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       master_clear_enable_fuse,
  input wire logic [7:0] wide_port_in,
  input wire logic [7:0] wide_port_out,
  input wire logic [7:0] wide_port_oe,
  input wire logic [2:0] narrow_port_low_lines_oe,
  input wire logic       ccp_capture_in,
  input wire logic [7:0] analog_select_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire rd_nd = reg_rd && reg_addr == `DGP_OFS_NARROW_DATA;
  wire rd_nr = reg_rd && reg_addr == `DGP_OFS_NARROW_DIR;
  wire wr_wr = reg_wr && reg_addr == `DGP_OFS_WIDE_DIR;
  wire wr_wd = reg_wr && reg_addr == `DGP_OFS_WIDE_DATA;
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_narrow_hi;
    $past(rd_nd) || $past(rd_nr) |-> reg_rdata[7:4] == 4'h0;
  endproperty
  a_narrow_hi: assert property (p_narrow_hi) else $error("narrow upper bits not zero");
  property p_dir3;
    $past(rd_nr) |-> reg_rdata[3];
  endproperty
  a_dir3: assert property (p_dir3) else $error("input-only direction bit not one");
  property p_fuse;
    $past(rd_nd) && $past(master_clear_enable_fuse) |-> !reg_rdata[3];
  endproperty
  a_fuse: assert property (p_fuse) else $error("top line readable with fuse set");
  property p_dir_oe;
    wr_wr ##1 !wr_wr |-> ##1 wide_port_oe[1] == !$past(reg_wdata[1], 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("line one enable not from direction");
  property p_out_latch;
    wr_wd ##1 !wr_wd |-> ##1 (!wide_port_oe[1] || wide_port_out[1] == $past(reg_wdata[1], 2));
  endproperty
  a_out_latch: assert property (p_out_latch) else $error("line one drive not from latch");
  property p_reset_state;
    $rose(nrst) |-> wide_port_oe == 8'h00 && narrow_port_low_lines_oe == 3'h0 && analog_select_out == 8'hFF;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
  property p_capture;
    $past(nrst, 2) && $past(nrst) |-> ccp_capture_in == $past(wide_port_in[2], 2);
  endproperty
  a_capture: assert property (p_capture) else $error("capture input not line two");
  property p_analog_select_gate;
    narrow_port_low_lines_oe[0] |-> !$past(analog_select_out[5]);
  endproperty
  a_analog_select_gate: assert property (p_analog_select_gate) else $error("analog line driven");
endmodule // dgp_chk

bind dgp_dual_port dgp_chk dgp_chk_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .master_clear_enable_fuse, .wide_port_in, .wide_port_out, .wide_port_oe, .narrow_port_low_lines_oe,
  .ccp_capture_in, .analog_select_out);

// File: bench/dgp_board.sv
/*
  Board model: resolves each pin level from the block's drive and the board's.
  Assumes the bench sets the board drive; the block wins any contention.
*/
module dgp_board (
  input  wire logic       clk,
  input  wire logic [7:0] w_out,
  input  wire logic [7:0] w_oe,
  input  wire logic [2:0] n_out,
  input  wire logic [2:0] n_oe,
  input  wire logic [7:0] bw_en,
  input  wire logic [7:0] bw_val,
  input  wire logic [2:0] bn_en,
  input  wire logic [3:0] bn_val,
  output wire logic [7:0] w_pin,
  output wire logic [3:0] n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Pin resolution
  // ********************
  // Floating lines toggle every cycle so a stale value can never pass a read.
  logic [7:0] idle_q = 8'h55;
  always @(posedge clk)
    idle_q <= ~idle_q;
  assign w_pin = (w_oe & w_out) | (~w_oe & bw_en & bw_val) | (~w_oe & ~bw_en & idle_q);
  assign n_pin[2:0] = (n_oe & n_out) | (~n_oe & bn_en & bn_val[2:0]) | (~n_oe & ~bn_en & idle_q[2:0]);
  assign n_pin[3] = bn_val[3];
endmodule // dgp_board

// File: bench/dgp_tb.sv
/*
  Self-checking bench for the dual GPIO port block with a board model.
  Assumes the checker is bound to the block and the constants header is on the path.
*/
`include "dgp_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, fuse = 1, ccp_o = 0, ccp_en = 0, com = 0, com_en = 0;
  logic [8:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, seg = 0, seg_en = 0, bw_en = 0, bw_val = 0, rdata, w_pin, w_out, w_oe, analog_select;
  logic [3:0] bn_val = 4'h8, n_pin;
  logic [2:0] bn_en = 0, n_out, n_oe;
  logic       cap;
  int         num_errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  dgp_dual_port dgp_dual_port_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata),
    .master_clear_enable_fuse(fuse), .wide_port_in(w_pin), .wide_port_out(w_out), .wide_port_oe(w_oe),
    .narrow_port_in(n_pin), .narrow_port_low_lines_out(n_out), .narrow_port_low_lines_oe(n_oe),
    .ccp_out(ccp_o), .ccp_out_en(ccp_en), .ccp_capture_in(cap), .lcd_segment_line(seg),
    .lcd_segment_drive_en(seg_en), .lcd_common_line(com), .lcd_common_drive_en(com_en),
    .analog_select_out(analog_select));
  dgp_board dgp_board_i (.clk, .w_out, .w_oe, .n_out, .n_oe, .bw_en, .bw_val, .bn_en, .bn_val, .w_pin, .n_pin);
  // ********************
  // Bus tasks and scenarios
  // ********************
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    `CHK(rdata, e)
  endtask
  // Three edges cover the enable register stage plus the two-flop pin sync.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    `CHK(w_oe, 8'h00)
    `CHK(n_oe, 3'h0)
    rdc(`DGP_OFS_WIDE_DIR, 8'hFF);
    rdc(`DGP_OFS_NARROW_DIR, 8'h0F);
    rdc(9'h155, 8'h00);
  endtask
  task automatic t_wide;
    wr(`DGP_OFS_WIDE_DATA, 8'hA5);
    wr(`DGP_OFS_WIDE_DIR, 8'h00);
    step(3);
    `CHK(w_oe, 8'hFF)
    `CHK(w_out, 8'hA5)
    rdc(`DGP_OFS_WIDE_DATA, 8'hA5);
    @(posedge clk);
    bw_en <= 8'hF0;
    bw_val <= 8'h3C;
    wr(`DGP_OFS_WIDE_DIR, 8'hF0);
    step(3);
    `CHK(w_oe, 8'h0F)
    rdc(`DGP_OFS_WIDE_DATA, 8'h35);
    wr(`DGP_OFS_WIDE_DATA, 8'h5A);
    step(3);
    `CHK(w_out & w_oe, 8'h0A)
    wr(`DGP_OFS_WIDE_DIR, 8'h00);
    step(3);
    `CHK(w_out, 8'h5A)
  endtask
  task automatic t_narrow;
    wr(`DGP_OFS_NARROW_DATA, 8'h00);
    wr(`DGP_OFS_NARROW_DIR, 8'h0F);
    wr(`DGP_OFS_ANALOG_SEL, 8'h00);
    wr(`DGP_OFS_NARROW_DATA, 8'hF5);
    wr(`DGP_OFS_NARROW_DIR, 8'h00);
    step(3);
    `CHK(n_oe, 3'h7)
    `CHK(n_out, 3'h5)
    `CHK(analog_select, 8'h00)
    rdc(`DGP_OFS_NARROW_DIR, 8'h08);
    rdc(`DGP_OFS_NARROW_DATA, 8'h05);
    @(posedge clk);
    fuse <= 1'h0;
    rdc(`DGP_OFS_NARROW_DATA, 8'h0D);
    wr(`DGP_OFS_NARROW_DIR, 8'h05);
    step(3);
    `CHK(n_oe, 3'h2)
    wr(`DGP_OFS_ANALOG_SEL, 8'hFF);
    step(3);
    `CHK(n_oe, 3'h0)
    `CHK(analog_select, 8'hFF)
  endtask
  task automatic t_alt;
    wr(`DGP_OFS_PERIPH_CTRL, 8'h03);
    wr(`DGP_OFS_SEG_ENABLE, 8'h1F);
    @(posedge clk);
    ccp_en <= 1'h1;
    ccp_o <= 1'h1;
    seg <= 8'h15;
    seg_en <= 8'h1B;
    com <= 1'h1;
    com_en <= 1'h1;
    step(3);
    `CHK(w_out[2], 1'h1)
    `CHK(w_out[7:3], 5'h15)
    `CHK(w_oe[7:3], 5'h1B)
    `CHK(w_out[0], 1'h1)
    @(posedge clk);
    ccp_en <= 1'h0;
    bw_en <= 8'h04;
    bw_val <= 8'h04;
    wr(`DGP_OFS_WIDE_DIR, 8'h04);
    step(3);
    `CHK(cap, 1'h1)
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    step(1);
    t_reset;
    t_wide;
    t_narrow;
    t_alt;
    tally_and_finish;
  end
  initial
  begin
    #50000;
    num_errors++;
    tally_and_finish;
  end
endmodule // testbench
